// ---- shared/adc_readout_pkg.sv ----
package adc_readout_pkg;

    localparam int RESULT_BITS = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 5;
    localparam int IDX_W = 4;

    // Falling data-clock edges counted after select falls.
    localparam logic [4:0] EDGE_ACQUIRE = 5'h01;
    localparam logic [4:0] EDGE_HOLD = 5'h02;
    localparam logic [4:0] EDGE_MSB = 5'h03;
    localparam logic [4:0] EDGE_LSB = 5'h0E;
    localparam logic [4:0] EDGE_TAIL_LAST = 5'h19;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [4:0] CNT_RST = 5'h00;

    localparam logic SAMPLE_HOLD_RST = 1'b1;
    localparam logic POWER_RST = 1'b0;
    localparam logic OE_RST = 1'b0;
    localparam logic DOUT_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ACQUIRE = 3'h1,
        ST_CONVERT = 3'h2,
        ST_TAIL = 3'h3,
        ST_ZERO = 3'h4
    } link_state_e;

endpackage

// ---- design/level_sync.sv ----
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,              // destination clock
    input wire logic [WIDTH-1:0] d_in,    // asynchronous levels
    output logic [WIDTH-1:0] q_out        // synchronised levels
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_in) begin
        meta_reg <= d_in;
        stable_reg <= meta_reg;
    end

    assign q_out = stable_reg;

endmodule

// ---- design/word_fifo.sv ----
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,              // core clock
    input wire logic rst_b_in,            // synchronous reset, low
    input wire logic [WIDTH-1:0] wr_data_in,  // write word
    input wire logic wr_valid_in,         // write offered
    output logic wr_ready_out,            // room for a word
    output logic [WIDTH-1:0] rd_data_out, // head word
    output logic rd_valid_out,            // head word present
    input wire logic rd_ready_in          // head word taken
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W:0] wr_ptr_reg;
    logic [PTR_W:0] rd_ptr_reg;
    logic empty;
    logic full;
    logic do_wr;
    logic do_rd;

    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
                  (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
    assign do_wr = wr_valid_in && !full;
    assign do_rd = rd_ready_in && !empty;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem_reg[rd_ptr_reg[PTR_W-1:0]];

    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem_reg[wr_ptr_reg[PTR_W-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
            rd_ptr_reg <= do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        end
    end

endmodule

// ---- design/serial_adc_readout_port.sv ----
// Function
// RQ1 - Select low runs, select high shuts down.
// RQ2 - Each result word is twelve bits.
// RQ3 - Output changes on falling clock, host samples rising.
// RQ4 - Select falling edge starts sample and convert.
// RQ5 - Output driver enabled at second clock pulse.
// RQ6 - One null bit, then twelve result bits.
// RQ7 - Conversion advances one step per data clock.
// RQ8 - Select high abandons transfer, resets interface.
// RQ9 - Power down bias and reference after conversion.
// RQ10 - Extra clocks give LSB-first copy, then zeros.
// RQ11 - Power down without select rising; interface stays.
// RQ12 - Host keeps select low briefly for power.
// RQ13 - Input acquired 1.5 to 2 clocks first.
// RQ14 - Output goes high impedance after select rises.
// RQ15 - Host stays below 20 kHz conversion rate.
// RQ16 - First result word goes out MSB first.
// RQ17 - Deselected device ignores clock, counters held.
`timescale 1ns/1ps
module serial_adc_readout_port
    import adc_readout_pkg::*;
#(
    parameter int WIDTH = RESULT_BITS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic core_clk_in,             // core clock, 50 MHz
    input wire logic rst_b_in,                // core reset, low
    input wire logic [WIDTH-1:0] result_data_in, // converted word
    input wire logic result_valid_in,         // word offered
    output logic result_ready_out,            // buffer has room
    output logic word_waiting_out,            // word held for link
    output logic shutdown_out,                // select is high
    input wire logic select_shutdown_n_in,    // select pin, low
    input wire logic serial_data_clock_in,    // host data clock
    output logic serial_data_out,             // serial data level
    output logic serial_data_oe_out,          // serial data driven
    output logic sample_hold_out,             // input tracking
    output logic converter_power_out,         // bias, comparator on
    output logic reference_hiz_out            // reference released
);

    // Core domain.

    logic [WIDTH-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [WIDTH-1:0] hold_reg;
    logic hold_full_reg;
    logic hold_full_next;
    logic wait_low_reg;
    logic wait_low_next;
    logic ack_s;
    logic cs_s;
    logic ack_reg;

    word_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .wr_data_in(result_data_in),
        .wr_valid_in(result_valid_in),
        .wr_ready_out(result_ready_out),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop)
    );

    level_sync #(
        .WIDTH(2)
    ) u_core_sync (
        .clk_in(core_clk_in),
        .d_in({select_shutdown_n_in, ack_reg}),
        .q_out({cs_s, ack_s})
    );

    // Four-phase handshake: the held word stays stable until the link
    // has acknowledged it and the acknowledge has dropped again.
    assign fifo_pop = fifo_valid && !hold_full_reg && !wait_low_reg &&
                      !ack_s;
    assign hold_full_next = fifo_pop ? 1'b1 :
                            (ack_s ? 1'b0 : hold_full_reg);
    assign wait_low_next = (hold_full_reg && ack_s) ? 1'b1 :
                           (ack_s ? wait_low_reg : 1'b0);

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            hold_full_reg <= 1'b0;
            wait_low_reg <= 1'b0;
        end else begin
            hold_full_reg <= hold_full_next;
            wait_low_reg <= wait_low_next;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            hold_reg <= '0;
        end else if (fifo_pop) begin
            hold_reg <= fifo_data;
        end
    end

    assign word_waiting_out = hold_full_reg;
    assign shutdown_out = cs_s; // [RQ1]

    // Link domain, clocked on the falling data-clock edge.

    logic link_clk_n;
    logic full_s;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    link_state_e state_reg;
    link_state_e state_next;
    logic [WIDTH-1:0] word_reg;
    logic [WIDTH-1:0] word_next;
    logic take_word;
    logic ack_next;
    logic [IDX_W-1:0] msb_idx;
    logic [IDX_W-1:0] lsb_idx;
    logic msb_bit;
    logic lsb_bit;
    logic dout_next;
    logic oe_next;
    logic sample_next;
    logic power_next;
    logic conv_done;

    assign link_clk_n = ~serial_data_clock_in; // [RQ3]

    level_sync #(
        .WIDTH(1)
    ) u_link_sync (
        .clk_in(link_clk_n),
        .d_in(hold_full_reg),
        .q_out(full_s)
    );

    // The count saturates, so a long run of zeros cannot wrap it.
    assign cnt_next = (cnt_reg == CNT_MAX) ? cnt_reg :
                      CNT_W'(cnt_reg + 5'h01);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                state_next = ST_ACQUIRE; // [RQ4]
            end
            ST_ACQUIRE: begin
                if (cnt_next == EDGE_HOLD) begin
                    state_next = ST_CONVERT; // [RQ13]
                end
            end
            ST_CONVERT: begin
                if (cnt_next > EDGE_LSB) begin
                    state_next = ST_TAIL; // [RQ10]
                end
            end
            ST_TAIL: begin
                if (cnt_next > EDGE_TAIL_LAST) begin
                    state_next = ST_ZERO; // [RQ10]
                end
            end
            ST_ZERO: begin
                state_next = ST_ZERO;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // A word is taken once per frame at the first falling edge; a frame
    // with no fresh word sends zeros rather than stale data.
    assign take_word = (cnt_next == EDGE_ACQUIRE) && full_s && !ack_reg;
    assign word_next = take_word ? hold_reg : // [RQ2]
                       ((cnt_next == EDGE_ACQUIRE) ? '0 : word_reg);
    assign ack_next = take_word ? 1'b1 : (full_s ? ack_reg : 1'b0);

    assign msb_idx = IDX_W'(EDGE_LSB - cnt_next); // [RQ16]
    assign lsb_idx = IDX_W'(cnt_next - EDGE_LSB);
    assign msb_bit = (msb_idx < IDX_W'(WIDTH)) ? word_reg[msb_idx] : 1'b0;
    assign lsb_bit = (lsb_idx < IDX_W'(WIDTH)) ? word_reg[lsb_idx] : 1'b0;

    assign dout_next = (state_next == ST_CONVERT) ?
                       ((cnt_next == EDGE_HOLD) ? 1'b0 : msb_bit) : // [RQ6]
                       ((state_next == ST_TAIL) ? lsb_bit : 1'b0); // [RQ10]
    assign oe_next = (state_next == ST_CONVERT) ||
                     (state_next == ST_TAIL) ||
                     (state_next == ST_ZERO); // [RQ5]
    assign sample_next = (state_next == ST_ACQUIRE); // [RQ13]
    assign conv_done = (cnt_next >= EDGE_LSB);
    assign power_next = ((state_next == ST_ACQUIRE) ||
                         (state_next == ST_CONVERT)) && !conv_done; // [RQ9]

    // Select high acts as the asynchronous clear of the link side, all but the
    // u_link_sync synchroniser, so the interface is idle and the driver released
    // without needing any data-clock edge.
    always_ff @(posedge link_clk_n or posedge select_shutdown_n_in) begin
        if (select_shutdown_n_in) begin
            cnt_reg <= CNT_RST; // [RQ17]
            state_reg <= ST_IDLE; // [RQ8]
            word_reg <= '0;
            ack_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next; // [RQ7]
            state_reg <= state_next;
            word_reg <= word_next;
            ack_reg <= ack_next;
        end
    end

    always_ff @(posedge link_clk_n or posedge select_shutdown_n_in) begin
        if (select_shutdown_n_in) begin
            serial_data_out <= DOUT_RST;
            serial_data_oe_out <= OE_RST; // [RQ14]
            sample_hold_out <= SAMPLE_HOLD_RST;
            converter_power_out <= POWER_RST; // [RQ1]
        end else begin
            serial_data_out <= dout_next; // [RQ3]
            serial_data_oe_out <= oe_next;
            sample_hold_out <= sample_next;
            converter_power_out <= power_next; // [RQ11]
        end
    end

    assign reference_hiz_out = !converter_power_out; // [RQ9]

    // Checks on the link side.

    property p_oe_second;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        $rose(serial_data_oe_out) |-> (cnt_reg == EDGE_HOLD);
    endproperty
    a_oe_second: assert property (p_oe_second) // [RQ5]
        else $error("Output enabled at the wrong edge.");

    property p_null_bit;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        (cnt_reg == EDGE_HOLD) |-> (serial_data_oe_out && !serial_data_out);
    endproperty
    a_null_bit: assert property (p_null_bit) // [RQ6]
        else $error("Null bit missing.");

    property p_msb_first;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        (cnt_reg == EDGE_MSB) |-> (serial_data_out == word_reg[WIDTH-1])
        ##11 (serial_data_out == word_reg[0]);
    endproperty
    a_msb_first: assert property (p_msb_first) // [RQ16]
        else $error("Result word not sent MSB first.");

    property p_lsb_tail;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        (cnt_reg == EDGE_LSB) ##1 (cnt_reg == 5'h0F) |->
        (serial_data_out == word_reg[1]);
    endproperty
    a_lsb_tail: assert property (p_lsb_tail) // [RQ10]
        else $error("LSB-first copy wrong.");

    property p_zeros;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        (cnt_reg > EDGE_TAIL_LAST) |-> !serial_data_out;
    endproperty
    a_zeros: assert property (p_zeros) // [RQ10]
        else $error("Tail after the copy is not zero.");

    property p_power_down;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        (cnt_reg >= EDGE_LSB) |-> (!converter_power_out &&
                                    reference_hiz_out);
    endproperty
    a_power_down: assert property (p_power_down) // [RQ9]
        else $error("Converter still powered after conversion.");

    property p_conv_step;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        (state_reg == ST_CONVERT) && (cnt_reg < EDGE_LSB) |=>
        (cnt_reg == CNT_W'($past(cnt_reg) + 5'h01)) &&
        (converter_power_out == (cnt_reg < EDGE_LSB));
    endproperty
    a_conv_step: assert property (p_conv_step) // [RQ7]
        else $error("Conversion did not advance by one step.");

    property p_acquire;
        @(posedge link_clk_n) disable iff (select_shutdown_n_in)
        (cnt_reg == EDGE_ACQUIRE) |-> sample_hold_out && converter_power_out
        ##1 !sample_hold_out;
    endproperty
    a_acquire: assert property (p_acquire) // [RQ13]
        else $error("Acquisition window wrong.");

    // Checks on the core side.

    property p_shutdown;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        select_shutdown_n_in [*3] |-> shutdown_out;
    endproperty
    a_shutdown: assert property (p_shutdown) // [RQ1]
        else $error("Shutdown not reported after select high.");

    property p_release;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (hold_full_reg && ack_s) |=> !hold_full_reg ##1 !fifo_pop;
    endproperty
    a_release: assert property (p_release) // [RQ8]
        else $error("Held word not released on acknowledge.");

endmodule

// ---- test/serial_host_model.sv ----
`timescale 1ns/1ps
module serial_host_model #(
    parameter real HALF = 7.5,
    parameter real MIN_GAP = 50000.0
) (
    output logic select_shutdown_n_out, // select pin, low
    output logic serial_data_clock_out, // host data clock
    input wire logic serial_data_in, // serial data level
    input wire logic serial_data_oe_in, // serial data driven
    input wire logic converter_power_in, // bias on
    input wire logic sample_hold_in // input tracking
);
    logic [31:0] data_bits;
    logic [31:0] oe_bits;
    logic [31:0] power_bits;
    logic [31:0] hold_bits;
    real last_start;

    // A falling clock edge with select high gives the link side a defined
    // clear at start-up instead of relying on time-zero event ordering.
    initial begin
        select_shutdown_n_out = 1'b1;
        serial_data_clock_out = 1'b1;
        last_start = -MIN_GAP;
        #1 serial_data_clock_out = 1'b0;
    end

    // Index k holds what was seen on the rise after falling edge k.
    task automatic run_frame(input int n);
        int k;
        #3;
        while ($realtime - last_start < MIN_GAP) #HALF;
        // Pulses while deselected must be ignored by the counters.
        for (k = 0; k < 3; k++) begin
            #HALF serial_data_clock_out = 1'b1;
            #HALF serial_data_clock_out = 1'b0;
        end
        #HALF select_shutdown_n_out = 1'b0;
        last_start = $realtime;
        for (k = 0; k <= n; k++) begin
            #HALF serial_data_clock_out = 1'b1;
            if (k > 0) begin
                // A released line must not pass for valid data.
                data_bits[k] = serial_data_oe_in ? serial_data_in :
                               ~serial_data_in;
                oe_bits[k] = serial_data_oe_in;
                power_bits[k] = converter_power_in;
                hold_bits[k] = sample_hold_in;
            end
            if (k < n) #HALF serial_data_clock_out = 1'b0;
        end
        #HALF select_shutdown_n_out = 1'b1;
        #HALF serial_data_clock_out = 1'b0;
    endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    import adc_readout_pkg::*;
    logic core_clk_in;
    logic rst_b_in;
    logic [11:0] result_data_in;
    logic result_valid_in;
    logic result_ready_out;
    logic word_waiting_out;
    logic shutdown_out;
    logic select_n;
    logic dclk;
    logic serial_data_out;
    logic serial_data_oe_out;
    logic sample_hold_out;
    logic converter_power_out;
    logic reference_hiz_out;
    int fail_count = 0;
    int checks = 0;

    serial_adc_readout_port serial_adc_readout_port_i (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .result_data_in(result_data_in),
        .result_valid_in(result_valid_in),
        .result_ready_out(result_ready_out),
        .word_waiting_out(word_waiting_out),
        .shutdown_out(shutdown_out),
        .select_shutdown_n_in(select_n),
        .serial_data_clock_in(dclk),
        .serial_data_out(serial_data_out),
        .serial_data_oe_out(serial_data_oe_out),
        .sample_hold_out(sample_hold_out),
        .converter_power_out(converter_power_out),
        .reference_hiz_out(reference_hiz_out)
    );

    serial_host_model serial_host_model_i (
        .select_shutdown_n_out(select_n),
        .serial_data_clock_out(dclk),
        .serial_data_in(serial_data_out),
        .serial_data_oe_in(serial_data_oe_out),
        .converter_power_in(converter_power_out),
        .sample_hold_in(sample_hold_out)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic exp_bit(input logic [11:0] w, input int k);
        if (k >= 3 && k <= 14) return w[14-k];
        if (k >= 15 && k <= 25) return w[k-14];
        return 1'b0;
    endfunction

    task automatic offer(input logic [11:0] w, output logic ok);
        int t;
        ok = 1'b0;
        @(posedge core_clk_in);
        #1 result_data_in = w;
        result_valid_in = 1'b1;
        for (t = 0; t < 20 && !ok; t++) begin
            ok = (result_ready_out === 1'b1);
            @(posedge core_clk_in);
            #1;
        end
        result_valid_in = 1'b0;
    endtask

    task automatic wait_word();
        int t;
        for (t = 0; t < 100 && word_waiting_out !== 1'b1; t++)
            @(posedge core_clk_in);
        #1 check("waiting", 12'h001, {11'h000, word_waiting_out});
    endtask

    task automatic do_frame(input logic [11:0] w, input int n);
        int k;
        fork
            serial_host_model_i.run_frame(n);
            begin
                wait (select_n === 1'b0);
                repeat (4) @(posedge core_clk_in);
                #1 check("shutdown", 12'h000, shutdown_out);
            end
        join
        for (k = 1; k <= n; k++) begin
            check("oe", k >= 2, serial_host_model_i.oe_bits[k]);
            if (k >= 2)
                check("data", exp_bit(w, k),
                      serial_host_model_i.data_bits[k]);
            check("power", k < 14,
                  serial_host_model_i.power_bits[k]);
            check("hold", k == 1, serial_host_model_i.hold_bits[k]);
        end
    endtask

    task automatic send(input logic [11:0] w, input int n);
        logic ok;
        offer(w, ok);
        check("taken", 12'h001, {11'h000, ok});
        wait_word();
        do_frame(w, n);
    endtask

    task automatic test_reset();
        check("ready", 12'h001, result_ready_out);
        check("waiting", 12'h000, word_waiting_out);
        check("shutdown", 12'h001, shutdown_out);
        check("oe", 12'h000, serial_data_oe_out);
        check("hold", 12'h001, sample_hold_out);
        check("ref_hiz", 12'h001, reference_hiz_out);
    endtask

    task automatic test_words();
        send(12'hA5C, 30);
        check("waiting", 12'h000, word_waiting_out);
        send(12'h801, 30);
    endtask

    // A frame cut short must leave nothing behind for the next one.
    task automatic test_abort();
        send(12'h3C5, 8);
        check("oe", 12'h000, serial_data_oe_out);
        check("hold", 12'h001, sample_hold_out);
        check("power", 12'h000, converter_power_out);
        check("ref_hiz", 12'h001, reference_hiz_out);
        send(12'hFFF, 30);
    endtask

    // The hold stage takes one word, so one more than the depth fits.
    task automatic test_fifo();
        int t;
        int acc;
        acc = 0;
        @(posedge core_clk_in);
        #1 result_valid_in = 1'b1;
        for (t = 0; t < 14; t++) begin
            result_data_in = 12'h100 + 12'(acc);
            if (result_ready_out === 1'b1) acc++;
            @(posedge core_clk_in);
            #1;
        end
        result_valid_in = 1'b0;
        check("ready", 12'h000, result_ready_out);
        check("accepted", 12'(FIFO_DEPTH + 1), 12'(acc));
        for (t = 0; t < acc; t++) begin
            wait_word();
            do_frame(12'h100 + 12'(t), 30);
        end
    endtask

    task automatic test_idle();
        check("waiting", 12'h000, word_waiting_out);
        do_frame(12'h000, 30);
    endtask

    initial begin
        rst_b_in = 1'b0;
        result_data_in = 12'h000;
        result_valid_in = 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1 rst_b_in = 1'b1;
        test_reset();
        test_words();
        test_abort();
        test_fifo();
        test_idle();
        conclude();
    end

    initial begin
        #1500000;
        fail_count++;
        conclude();
    end
endmodule
